// ===== mem_pwr_map.svh
/*
 * Constants of the memory power and configuration block: timing figures
 * in their own units, cycle counts derived from them, and decode bases.
 * Assumes the system clock period given below.
 */
`ifndef MEM_PWR_MAP_SVH
`define MEM_PWR_MAP_SVH

`define CLK_PERIOD_NS    10
`define DLL_LOCK_NS      2000
`define SR_EXIT_NS       1400
`define PD_EXIT_NS       30
// Least times round up to whole cycles.
`define DLL_LOCK_CYC     12'((`DLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR_EXIT_CYC      12'((`SR_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PD_EXIT_CYC      12'((`PD_EXIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NARROW_16        1'h1
`define PAGE_BASE_WORDS  12'h100
`define TIMING_RST       32'h0000_0000

`endif

// ===== mem_pwr_pkg.sv
/*
 * Types shared by the memory power and configuration block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package mem_pwr_pkg;

    typedef enum logic [2:0] {
        ST_ACTIVE, ST_DRAIN, ST_SELF_REF, ST_CLK_STOP,
        ST_RELOCK, ST_EXIT, ST_POWER_DOWN
    } pm_state_t;

    typedef struct packed {
        logic       narrow_bus_select;
        logic [2:0] cas_latency_field;
        logic [2:0] internal_bank_count;
        logic [2:0] column_width_select;
    } cfg_in_t;

    typedef struct packed {
        logic        bus16;
        logic [2:0]  cas_cycles;
        logic [3:0]  bank_count;
        logic [11:0] page_words;
    } cfg_out_t;

endpackage : mem_pwr_pkg

`default_nettype wire

// ===== refresh_sched.sv
/*
 * Periodic refresh timer with a backlog count of refreshes still owed.
 * Assumes one memory clock cycle per sys_clk cycle and that the caller
 * pulses done once per refresh issued.
 */
`default_nettype none

module refresh_sched
    import mem_pwr_pkg::*;
#(
    parameter int RR_W        = 13,
    parameter int BL_W        = 4,
    parameter int BACKLOG_MAX = 8
) (
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire logic            run,
    input  wire logic [RR_W-1:0] interval,
    input  wire logic            done,
    output logic      [BL_W-1:0] backlog
);

    logic [RR_W-1:0] cnt_r;
    logic [BL_W-1:0] backlog_r;
    logic            due;

    if (BACKLOG_MAX < 1 || BACKLOG_MAX >= 2 ** BL_W) begin : g_bad_cfg
        $error("refresh_sched: BACKLOG_MAX does not fit BL_W");
    end

    // An interval of zero stops the timer rather than refreshing nonstop.
    assign due = run && (interval != '0) && (cnt_r >= interval - RR_W'(1));
    assign backlog = backlog_r;

    // Interval counter; cleared while the memory refreshes itself.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (!run || due) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + RR_W'(1);
        end
    end

    // Owed refreshes; a new one due in the cycle of a done is kept unless the backlog is at BACKLOG_MAX.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            backlog_r <= '0;
        end else begin
            unique case ({due && backlog_r < BL_W'(BACKLOG_MAX),
                          done && backlog_r != '0})
                2'b10:   backlog_r <= backlog_r + BL_W'(1);
                2'b01:   backlog_r <= backlog_r - BL_W'(1);
                default: backlog_r <= backlog_r;
            endcase
        end
    end

    a_refresh_due: assert property (@(posedge sys_clk) disable iff (!nrst)
        (due && !done && backlog_r < BL_W'(BACKLOG_MAX))
        |=> backlog_r == $past(backlog_r) + BL_W'(1))
        else $error("refresh falling due did not raise the backlog");

endmodule : refresh_sched

`default_nettype wire

// ===== mem_pwr_ctrl.sv
/*
 * Power management, clock stop and configuration decode for the external
 * DDR2/mobile DDR memory controller.
 * Assumes sys_clk is the memory clock domain, that acc_busy comes from
 * the data path on the same clock, and that clocks_gated arrives from
 * the clock controller outside this domain.
 */
`include "mem_pwr_map.svh"
`default_nettype none

module mem_pwr_ctrl
    import mem_pwr_pkg::*;
#(
    parameter int RR_W = 13
) (
    input  wire logic            sys_clk,
    input  wire logic            nrst,
    input  wire logic            low_power_mode_enable,
    input  wire logic            selfrefresh_or_powerdown_select,
    input  wire logic            memory_clock_stop_enable,
    input  wire logic            timing_register_unlock,
    input  wire cfg_in_t         cfg_in,
    input  wire logic [RR_W-1:0] refresh_interval_count,
    input  wire logic            clocks_gated,
    input  wire logic            acc_valid,
    input  wire logic            acc_busy,
    input  wire logic            timing_wr_one,
    input  wire logic            timing_wr_two,
    input  wire logic [31:0]     timing_wdata,
    output logic                 acc_ready,
    output logic                 phy_ready_flag,
    output logic                 memory_phy_clock_en,
    output logic                 cke,
    output logic                 dll_relock,
    output logic                 sr_enter,
    output logic                 sr_exit,
    output logic                 refresh_cmd,
    output cfg_out_t             cfg_out,
    output logic [31:0]          timing_one,
    output logic [31:0]          timing_two,
    output pm_state_t            pm_state
);

    pm_state_t   state_r, state_nxt;
    logic [11:0] cnt_r, cnt_val;
    logic        cnt_load;
    logic        gated_m_r, gated_s_r;
    logic        acc_ready_r, phy_ready_flag_r, phy_clk_en_r, cke_r;
    logic        dll_relock_r, sr_enter_r, sr_exit_r, refresh_cmd_r;
    cfg_out_t    cfg_out_r;
    logic [31:0] timing_one_r, timing_two_r;
    logic [3:0]  backlog;
    logic        ref_pending, ref_run, wake_req, lp_on;

    // Bounds for the wake path checks, in cycles.
    localparam int WAKE_MAX = 600;
    localparam int EXIT_MAX = 300;

    assign lp_on       = low_power_mode_enable;
    assign ref_pending = backlog != 4'h0;
    // Gated input clocks leave nothing to wake on.
    assign wake_req    = acc_valid && !gated_s_r;
    // The memory refreshes itself while in self-refresh, clock stop or DLL relock.
    assign ref_run     = !(state_r inside {ST_SELF_REF, ST_CLK_STOP,
                                            ST_RELOCK});

    // Two-flop synchroniser for the clock controller's gated level.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gated_m_r <= 1'b0;
            gated_s_r <= 1'b0;
        end else begin
            gated_m_r <= clocks_gated;
            gated_s_r <= gated_m_r;
        end
    end

    refresh_sched #(
        .RR_W        (RR_W),
        .BL_W        (4),
        .BACKLOG_MAX (8)
    ) u_refresh (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .run      (ref_run),
        .interval (refresh_interval_count),
        .done     (refresh_cmd_r),
        .backlog  (backlog)
    );

    // Power state sequencing. Debug halts have no input here, so the
    // sequencer keeps running through them.
    always_comb begin
        state_nxt = state_r;
        cnt_load  = 1'b0;
        cnt_val   = 12'h000;
        unique case (state_r)
            ST_ACTIVE: begin
                // Let a presented access through before draining.
                if (lp_on && !acc_valid) begin
                    state_nxt = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!lp_on) begin
                    state_nxt = ST_ACTIVE;
                end else if (!acc_busy && !ref_pending && !refresh_cmd_r) begin
                    state_nxt = selfrefresh_or_powerdown_select ?
                                ST_POWER_DOWN : ST_SELF_REF;
                end
            end
            ST_SELF_REF: begin
                if (!lp_on || wake_req) begin
                    state_nxt = ST_EXIT;
                    cnt_load  = 1'b1;
                    cnt_val   = `SR_EXIT_CYC;
                end else if (memory_clock_stop_enable) begin
                    state_nxt = ST_CLK_STOP;
                end
            end
            ST_CLK_STOP: begin
                if (wake_req || !memory_clock_stop_enable) begin
                    state_nxt = ST_RELOCK;
                    cnt_load  = 1'b1;
                    cnt_val   = `DLL_LOCK_CYC;
                end
            end
            ST_RELOCK: begin
                if (cnt_r == 12'h000) begin
                    state_nxt = ST_SELF_REF;
                end
            end
            ST_EXIT: begin
                if (cnt_r == 12'h000) begin
                    state_nxt = ST_ACTIVE;
                end
            end
            ST_POWER_DOWN: begin
                if (!lp_on || !selfrefresh_or_powerdown_select || wake_req) begin
                    state_nxt = ST_EXIT;
                    cnt_load  = 1'b1;
                    cnt_val   = `PD_EXIT_CYC;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_ACTIVE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wait counter shared by DLL relock and low-power exit.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 12'h000;
        end else if (cnt_load) begin
            cnt_r <= cnt_val;
        end else if (cnt_r != 12'h000) begin
            cnt_r <= cnt_r - 12'h001;
        end
    end

    // Memory-side controls follow the next state so they align with it.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phy_clk_en_r     <= 1'b1;
            phy_ready_flag_r <= 1'b1;
            cke_r            <= 1'b1;
            dll_relock_r     <= 1'b0;
            sr_enter_r       <= 1'b0;
            sr_exit_r        <= 1'b0;
        end else begin
            // The clock returns only once the DLL has relocked.
            phy_clk_en_r     <= !(state_nxt inside {ST_CLK_STOP,
                                   ST_RELOCK});
            // Flag drops one cycle after the clock is really off.
            phy_ready_flag_r <= phy_clk_en_r;
            cke_r            <= !(state_nxt inside {ST_SELF_REF,
                                   ST_CLK_STOP, ST_RELOCK, ST_POWER_DOWN});
            dll_relock_r     <= state_nxt == ST_RELOCK;
            sr_enter_r       <= state_r == ST_DRAIN
                                && state_nxt == ST_SELF_REF;
            sr_exit_r        <= state_r == ST_SELF_REF
                                && state_nxt == ST_EXIT;
        end
    end

    // Slave handshake only: requests are taken, no events are raised.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            acc_ready_r <= 1'b0;
        end else begin
            acc_ready_r <= state_nxt == ST_ACTIVE && !gated_s_r;
        end
    end

    // Owed refreshes go out between accesses, one at a time.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            refresh_cmd_r <= 1'b0;
        end else begin
            refresh_cmd_r <= ref_pending && !refresh_cmd_r && !acc_busy
                             && state_r inside {ST_ACTIVE, ST_DRAIN};
        end
    end

    // Configuration decode; registered so outputs stay glitch free.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_out_r <= '0;
        end else begin
            cfg_out_r.bus16      <= cfg_in.narrow_bus_select
                                    == `NARROW_16;
            cfg_out_r.cas_cycles <= cfg_in.cas_latency_field;
            cfg_out_r.bank_count <= 4'(4'h1
                                    << cfg_in.internal_bank_count[1:0]);
            cfg_out_r.page_words <= 12'(`PAGE_BASE_WORDS
                                    << cfg_in.column_width_select[1:0]);
        end
    end

    // Timing registers accept writes only while unlocked.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            timing_one_r <= `TIMING_RST;
            timing_two_r <= `TIMING_RST;
        end else if (timing_register_unlock) begin
            if (timing_wr_one) begin
                timing_one_r <= timing_wdata;
            end
            if (timing_wr_two) begin
                timing_two_r <= timing_wdata;
            end
        end
    end

    assign acc_ready           = acc_ready_r;
    assign phy_ready_flag      = phy_ready_flag_r;
    assign memory_phy_clock_en = phy_clk_en_r;
    assign cke                 = cke_r;
    assign dll_relock          = dll_relock_r;
    assign sr_enter            = sr_enter_r;
    assign sr_exit             = sr_exit_r;
    assign refresh_cmd         = refresh_cmd_r;
    assign cfg_out             = cfg_out_r;
    assign timing_one          = timing_one_r;
    assign timing_two          = timing_two_r;
    assign pm_state            = state_r;

    a_gated_no_accept: assert property (@(posedge sys_clk) disable iff (!nrst)
        gated_s_r |=> !acc_ready_r)
        else $error("access accepted while input clocks gated");

    a_drain_waits: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_DRAIN && (acc_busy || ref_pending))
        |=> state_r != ST_SELF_REF)
        else $error("self-refresh entered with work outstanding");

    a_stop_needs_en: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(phy_clk_en_r) |-> $past(memory_clock_stop_enable)
        && $past(state_r) == ST_SELF_REF)
        else $error("PHY clock stopped without enable or self-refresh");

    a_ready_flag_low: assert property (@(posedge sys_clk) disable iff (!nrst)
        !phy_clk_en_r |=> !phy_ready_flag_r)
        else $error("ready flag high after PHY clock stopped");

    a_wake_relock: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_CLK_STOP && wake_req)
        |=> dll_relock_r && phy_clk_en_r == 1'b0
        ##[1:WAKE_MAX] (acc_ready_r && phy_clk_en_r && cke_r))
        else $error("access in clock stop was not served in time");

    a_active_running: assert property (@(posedge sys_clk) disable iff (!nrst)
        state_r == ST_ACTIVE |-> cke_r && phy_clk_en_r)
        else $error("active state with memory not fully running");

    a_lp_clear_exit: assert property (@(posedge sys_clk) disable iff (!nrst)
        (state_r == ST_SELF_REF && !lp_on)
        |=> sr_exit_r ##[1:EXIT_MAX] state_r == ST_ACTIVE)
        else $error("self-refresh not left after low power cleared");

    a_timing_lock: assert property (@(posedge sys_clk) disable iff (!nrst)
        !timing_register_unlock
        |=> $stable(timing_one_r) && $stable(timing_two_r))
        else $error("timing register changed while locked");

    a_bus_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_in.narrow_bus_select |=> cfg_out_r.bus16)
        else $error("narrow bus select did not give 16-bit bus");

    a_cas_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_in.cas_latency_field == 3'h4 |=> cfg_out_r.cas_cycles == 3'h4)
        else $error("CAS field 4 did not give four cycles");

    a_bank_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_in.internal_bank_count == 3'h3
        |=> cfg_out_r.bank_count == 4'h8)
        else $error("bank field 3 did not give eight banks");

    a_page_decode: assert property (@(posedge sys_clk) disable iff (!nrst)
        cfg_in.column_width_select == 3'h2
        |=> cfg_out_r.page_words == 12'h400)
        else $error("column select 2 did not give 1024-word page");

endmodule : mem_pwr_ctrl

`default_nettype wire

// ===== sdram_model.sv
/*
 * Behavioural far side of the controller: the external memory, which
 * tracks self-refresh from the entry and exit commands, and the data
 * path, which stays busy for a few cycles after each accepted access.
 * Assumes the controller's commands are one-cycle pulses on sys_clk.
 */
`default_nettype none

module sdram_model (
    input  wire logic sys_clk,
    input  wire logic nrst,
    input  wire logic acc_take,
    input  wire logic refresh_cmd,
    input  wire logic sr_enter,
    input  wire logic sr_exit,
    output logic      acc_busy,
    output int        err_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic in_sr;
    int   busy_left;

    // A refresh command while the memory refreshes itself is counted bad.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            in_sr   <= 1'b0;
            err_cnt <= 0;
        end else begin
            if (sr_enter) in_sr <= 1'b1;
            if (sr_exit) in_sr <= 1'b0;
            if (refresh_cmd && in_sr) err_cnt <= err_cnt + 1;
        end
    end

    // Busy lasts six cycles so that a drain really has to wait.
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_left <= 0;
        end else if (acc_take) begin
            busy_left <= 6;
        end else if (busy_left > 0) begin
            busy_left <= busy_left - 1;
        end
    end

    assign acc_busy = (busy_left != 0);

endmodule : sdram_model

`default_nettype wire

// ===== tb.sv
/*
 * Self-checking bench of the memory power and configuration block:
 * configuration decode, timing lock, refresh spacing, self-refresh,
 * clock stop, wake by access, restart and power-down.
 * Assumes the block and the memory model sit on one 100 MHz clock.
 */
`default_nettype none

module tb
    import mem_pwr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, nrst, low_power_mode_enable;
    logic        selfrefresh_or_powerdown_select, memory_clock_stop_enable;
    logic        timing_register_unlock, clocks_gated, acc_valid, acc_busy;
    logic        timing_wr_one, timing_wr_two, acc_ready, phy_ready_flag;
    logic        memory_phy_clock_en, cke, dll_relock, sr_enter, sr_exit;
    logic        refresh_cmd, seen_relock, seen_exit, seen_enter;
    logic [12:0] refresh_interval_count;
    logic [31:0] timing_wdata, timing_one, timing_two;
    cfg_in_t     cfg_in;
    cfg_out_t    cfg_out;
    pm_state_t   pm_state;
    cfg_in_t     cin [3];
    cfg_out_t    cexp [3];
    int          n_errors, num_checks, model_err, gap, i;

    mem_pwr_ctrl #(.RR_W(13)) mem_pwr_ctrl_i (
        .sys_clk, .nrst, .low_power_mode_enable,
        .selfrefresh_or_powerdown_select, .memory_clock_stop_enable,
        .timing_register_unlock, .cfg_in, .refresh_interval_count,
        .clocks_gated, .acc_valid, .acc_busy, .timing_wr_one,
        .timing_wr_two, .timing_wdata, .acc_ready, .phy_ready_flag,
        .memory_phy_clock_en, .cke, .dll_relock, .sr_enter, .sr_exit,
        .refresh_cmd, .cfg_out, .timing_one, .timing_two, .pm_state
    );

    sdram_model sdram_model_i (
        .sys_clk, .nrst, .acc_take(acc_valid && acc_ready), .refresh_cmd,
        .sr_enter, .sr_exit, .acc_busy, .err_cnt(model_err)
    );

    // The entry and exit pulses and the relock level are latched so the tests can ask about them later.
    always @(posedge sys_clk) begin
        if (dll_relock) seen_relock <= 1'b1;
        if (sr_exit) seen_exit <= 1'b1;
        if (sr_enter) seen_enter <= 1'b1;
    end

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Bounded wait, so a state that never comes shows as a mismatch.
    task automatic wait_state(input pm_state_t s, input int lim);
        for (int k = 0; k < lim && pm_state !== s; k++) tick(1);
        check("pm_state", pm_state, s);
    endtask : wait_state

    task automatic ref_gap(input int lim, output int g);
        for (int k = 0; k < lim && refresh_cmd !== 1'b1; k++) tick(1);
        tick(1);
        g = 1;
        while (refresh_cmd !== 1'b1 && g < lim) begin
            tick(1);
            g++;
        end
    endtask : ref_gap

    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // The tests take about twelve hundred cycles; ten thousand is ample.
    initial begin
        #100000;
        n_errors++;
        results();
    end

    initial begin
        nrst = 1'b0;
        low_power_mode_enable = 1'b0;
        selfrefresh_or_powerdown_select = 1'b0;
        memory_clock_stop_enable = 1'b0;
        timing_register_unlock = 1'b0;
        clocks_gated = 1'b0;
        acc_valid = 1'b0;
        timing_wr_one = 1'b0;
        timing_wr_two = 1'b0;
        timing_wdata = 32'h0;
        refresh_interval_count = 13'h14;
        cin[0] = '{1'h1, 3'h4, 3'h3, 3'h2};
        cin[1] = '{1'h0, 3'h4, 3'h0, 3'h0};
        cin[2] = '{1'h0, 3'h4, 3'h2, 3'h1};
        cexp[0] = '{1'h1, 3'h4, 4'h8, 12'h400};
        cexp[1] = '{1'h0, 3'h4, 4'h1, 12'h100};
        cexp[2] = '{1'h0, 3'h4, 4'h4, 12'h200};
        cfg_in = cin[0];
        seen_relock = 1'b0;
        seen_exit = 1'b0;
        seen_enter = 1'b0;
        n_errors = 0;
        num_checks = 0;
        tick(6);
        check("phy_ready_flag", phy_ready_flag, 1'h1);
        check("cke", cke, 1'h1);
        check("timing_one", timing_one, 32'h0);
        tick(1);
        nrst = 1'b1;
        // Every decode entry is held two cycles to let the register land.
        for (i = 0; i < 3; i++) begin
            cfg_in = cin[i];
            tick(2);
            check("cfg_out", cfg_out, cexp[i]);
        end
        timing_register_unlock = 1'b1;
        timing_wdata = 32'h1234_5678;
        timing_wr_one = 1'b1;
        tick(1);
        timing_wr_one = 1'b0;
        timing_wdata = 32'h9abc_def0;
        timing_wr_two = 1'b1;
        tick(1);
        timing_wr_two = 1'b0;
        tick(1);
        check("timing_one", timing_one, 32'h1234_5678);
        check("timing_two", timing_two, 32'h9abc_def0);
        timing_register_unlock = 1'b0;
        timing_wdata = 32'h0f0f_0f0f;
        timing_wr_one = 1'b1;
        timing_wr_two = 1'b1;
        tick(1);
        timing_wr_one = 1'b0;
        timing_wr_two = 1'b0;
        tick(1);
        check("timing_one", timing_one, 32'h1234_5678);
        check("timing_two", timing_two, 32'h9abc_def0);
        ref_gap(100, gap);
        check("refresh_gap", gap, 32'd20);
        check("acc_ready", acc_ready, 1'h1);
        acc_valid = 1'b1;
        tick(1);
        acc_valid = 1'b0;
        // Entry is asked for while the data path is still busy.
        low_power_mode_enable = 1'b1;
        tick(2);
        check("pm_state", pm_state, ST_DRAIN);
        wait_state(ST_SELF_REF, 50);
        // The entry pulse is latched at the edge after it stands.
        tick(1);
        check("sr_enter", seen_enter, 1'h1);
        check("cke", cke, 1'h0);
        tick(3);
        check("phy_clock_en", memory_phy_clock_en, 1'h1);
        memory_clock_stop_enable = 1'b1;
        tick(3);
        check("phy_clock_en", memory_phy_clock_en, 1'h0);
        check("phy_ready_flag", phy_ready_flag, 1'h0);
        clocks_gated = 1'b1;
        // The gated level needs two edges to pass the synchroniser.
        tick(3);
        acc_valid = 1'b1;
        tick(300);
        check("acc_ready", acc_ready, 1'h0);
        check("pm_state", pm_state, ST_CLK_STOP);
        acc_valid = 1'b0;
        tick(1);
        clocks_gated = 1'b0;
        tick(5);
        seen_relock = 1'b0;
        acc_valid = 1'b1;
        for (i = 0; i < 500 && acc_ready !== 1'b1; i++) tick(1);
        check("acc_ready", acc_ready, 1'h1);
        check("dll_relock", seen_relock, 1'h1);
        check("phy_ready_flag", phy_ready_flag, 1'h1);
        tick(1);
        acc_valid = 1'b0;
        wait_state(ST_CLK_STOP, 100);
        seen_relock = 1'b0;
        memory_clock_stop_enable = 1'b0;
        wait_state(ST_SELF_REF, 300);
        check("dll_relock", seen_relock, 1'h1);
        tick(2);
        check("phy_ready_flag", phy_ready_flag, 1'h1);
        seen_exit = 1'b0;
        low_power_mode_enable = 1'b0;
        wait_state(ST_ACTIVE, 300);
        check("sr_exit", seen_exit, 1'h1);
        check("cke", cke, 1'h1);
        // Refreshes owed from the exit wait drain first, two cycles apart.
        tick(40);
        ref_gap(100, gap);
        check("refresh_gap", gap, 32'd20);
        // Power-down must not issue a self-refresh entry command.
        seen_enter = 1'b0;
        selfrefresh_or_powerdown_select = 1'b1;
        low_power_mode_enable = 1'b1;
        wait_state(ST_POWER_DOWN, 50);
        check("sr_enter", seen_enter, 1'h0);
        check("cke", cke, 1'h0);
        low_power_mode_enable = 1'b0;
        wait_state(ST_ACTIVE, 50);
        check("model_err", model_err, 32'h0);
        results();
    end

endmodule : tb

`default_nettype wire
